// ===== shared/gpp_map.svh
// Address map, reset values, bit masks and sizes of the GPIO ports block
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH

// Data-memory locations of the port registers
`define GPP_ADDR_A_DATA   8'h00
`define GPP_ADDR_A_DIR    8'h01
`define GPP_ADDR_A_PULL   8'h02
`define GPP_ADDR_A_WAKE   8'h03
`define GPP_ADDR_B_DATA   8'h04
`define GPP_ADDR_B_DIR    8'h05
`define GPP_ADDR_B_PULL   8'h06
`define GPP_ADDR_C_DATA   8'h07
`define GPP_ADDR_C_DIR    8'h08
`define GPP_ADDR_C_PULL   8'h09
`define GPP_ADDR_LV_PULL  8'h0A
`define GPP_ADDR_DRIVE_LO 8'h0B
`define GPP_ADDR_DRIVE_HI 8'h0C

// Implemented bits per register (others read as zero)
`define GPP_MASK_FULL     8'hFF
`define GPP_MASK_A_CTRL   8'hFB
`define GPP_MASK_C        8'h03
`define GPP_MASK_LV       8'h01

// Reset values
`define GPP_RST_DATA      8'hFF
`define GPP_RST_DIR       8'hFF
`define GPP_RST_PULL      8'h00
`define GPP_RST_WAKE      8'h00
`define GPP_RST_LV        8'h00
`define GPP_RST_DRIVE     8'h00
`define GPP_RST_RDATA     8'h00

// Port widths
`define GPP_A_W           8
`define GPP_B_W           8
`define GPP_C_W           2

`endif

// ===== shared/gpp_pkg.sv
// Types shared by the GPIO ports block
package gpp_pkg;

	// One bit per pin of ports A, B and C
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [1:0] c;
	} gpp_pins_s;

	// Source current levels, two bits per pin group
	typedef struct packed {
		logic [1:0] c_1_0;
		logic [1:0] b_7_4;
		logic [1:0] b_3_0;
		logic [1:0] a_7_4;
		logic [1:0] a_3_0;
	} gpp_drive_s;

	// Data-memory access from the core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} gpp_req_s;

endpackage

// ===== logic/gpp_sync.sv
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
module gpp_sync #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta; // First stage, read only by the second

	// Pins idle high under pull-up, so reset to ones avoids a false edge
	always_ff @(posedge clk) begin
		if (rst) begin
			meta     <= '1;
			sync_out <= '1;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule

// ===== logic/gpp_wake.sv
// Falling-edge wake detector for the port A pins
`timescale 1ns/1ps
module gpp_wake #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] level,
	input  wire logic [W-1:0] armed,
	input  wire logic         standby,
	output logic              wake
);

	logic [W-1:0] level_q; // Previous synchronised level

	// Remember last level for edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			level_q <= '1;
		end else begin
			level_q <= level;
		end
	end

	// High-to-low on an armed pin while asleep gives a one-cycle pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			wake <= 1'b0;
		end else begin
			wake <= standby && |(level_q & ~level & armed);
		end
	end

endmodule

// ===== logic/gpp_ports.sv
// Bidirectional I/O ports A, B and C with data-memory mapped control
`timescale 1ns/1ps
`include "gpp_map.svh"
// Function
// - Per-pin direction set by software anytime, except port A pin 2 (always input)
// - Port registers live in data memory
// - Input reads sample pins at second phase
// - Output latch holds until rewritten
// - Unimplemented control bits read as zero
// - Digital inputs may use weak pull-up
// - Per-pin pull enable, global strength select
// - Pull-up only for digital input/NMOS function
// - Drive and strength regs keep on sleep timeout
// - Output pins read back the latch
// - Port A falling edge wakes when enabled
// - Pull enable one on, zero off
module gpp_ports (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             wdt_timeout,
	input  wire logic             standby,
	input  wire gpp_pkg::gpp_req_s req,
	input  wire logic             second_instruction_phase,
	output logic      [7:0]       rdata,
	output logic                  rd_valid,
	input  wire gpp_pkg::gpp_pins_s pin_in,
	input  wire gpp_pkg::gpp_pins_s pull_allowed,
	input  wire logic [7:0]       port_a_gpio_sel,
	output gpp_pkg::gpp_pins_s    pin_out,
	output gpp_pkg::gpp_pins_s    pin_oe_n,
	output gpp_pkg::gpp_pins_s    pin_pullup_enable,
	output logic                  pull_strength,
	output gpp_pkg::gpp_drive_s   drive_level,
	output logic                  wake
);

	// Register contents
	logic [7:0] port_a_data;            // Port A output latch
	logic [7:0] port_a_direction;       // Port A direction
	logic [7:0] port_a_pullup_enable;   // Port A pull-up enables
	logic [7:0] port_a_wakeup_enable;   // Port A wake enables
	logic [7:0] port_b_data;            // Port B output latch
	logic [7:0] port_b_direction;       // Port B direction
	logic [7:0] port_b_pullup_enable;   // Port B pull-up enables
	logic [7:0] port_c_data;            // Port C output latch
	logic [7:0] port_c_direction;       // Port C direction
	logic [7:0] port_c_pullup_enable;   // Port C pull-up enables
	logic [7:0] low_voltage_pull_select; // Pull strength, bit 0
	logic [7:0] drive_strength_select_lo; // Port A/B source current
	logic [7:0] drive_strength_select_hi; // Port C source current

	// Derived controls
	logic       clr;        // Register reset condition
	logic       rd_take;    // Read accepted this cycle
	logic [7:0] next_rdata; // Read mux result
	logic [7:0] dir_a_eff;  // Port A direction with pin 2 forced input
	gpp_pkg::gpp_pins_s pin_sync; // Synchronised pin levels

	// Merge pin and latch per bit: inputs read pin, outputs read latch
	function automatic logic [7:0] read_mix(
		input logic [7:0] dir,
		input logic [7:0] latch,
		input logic [7:0] pin
	);
		read_mix = (dir & pin) | (~dir & latch);
	endfunction

	// Write decode for one register address
	function automatic logic hit(
		input gpp_pkg::gpp_req_s r,
		input logic [7:0]        a
	);
		hit = r.wr && (r.addr == a);
	endfunction

	// Watchdog timeout while asleep leaves everything unchanged
	assign clr = rst || (wdt_timeout && !standby);

	// Reads are taken only in the second instruction phase
	assign rd_take = req.rd && second_instruction_phase;

	// Pin 2 of port A has no direction bit and stays an input
	assign dir_a_eff = port_a_direction | ~`GPP_MASK_A_CTRL;

	// Pin levels come from outside the clock domain
	gpp_sync #(
		.W(18)
	) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in (pin_in),
		.sync_out (pin_sync)
	);

	// Falling edge on armed general purpose inputs of port A
	gpp_wake #(
		.W(`GPP_A_W)
	) u_wake (
		.clk     (clk),
		.rst     (rst),
		.level   (pin_sync.a),
		.armed   (port_a_wakeup_enable & dir_a_eff & port_a_gpio_sel),
		.standby (standby),
		.wake    (wake)
	);

	// Port A registers
	always_ff @(posedge clk) begin
		if (clr) begin
			port_a_data          <= `GPP_RST_DATA;
			port_a_direction     <= `GPP_RST_DIR & `GPP_MASK_A_CTRL;
			port_a_pullup_enable <= `GPP_RST_PULL;
			port_a_wakeup_enable <= `GPP_RST_WAKE;
		end else begin
			// Latch holds until this exact address is written
			if (hit(req, `GPP_ADDR_A_DATA)) begin
				port_a_data <= req.wdata;
			end
			// Direction may change at any time
			if (hit(req, `GPP_ADDR_A_DIR)) begin
				port_a_direction <= req.wdata & `GPP_MASK_A_CTRL;
			end
			// Bit 2 is not implemented in the control registers
			if (hit(req, `GPP_ADDR_A_PULL)) begin
				port_a_pullup_enable <= req.wdata & `GPP_MASK_A_CTRL;
			end
			if (hit(req, `GPP_ADDR_A_WAKE)) begin
				port_a_wakeup_enable <= req.wdata & `GPP_MASK_A_CTRL;
			end
		end
	end

	// Port B registers, all bits implemented
	always_ff @(posedge clk) begin
		if (clr) begin
			port_b_data          <= `GPP_RST_DATA;
			port_b_direction     <= `GPP_RST_DIR;
			port_b_pullup_enable <= `GPP_RST_PULL;
		end else begin
			// Output latch
			if (hit(req, `GPP_ADDR_B_DATA)) begin
				port_b_data <= req.wdata;
			end
			// Direction
			if (hit(req, `GPP_ADDR_B_DIR)) begin
				port_b_direction <= req.wdata;
			end
			// Pull-up enables
			if (hit(req, `GPP_ADDR_B_PULL)) begin
				port_b_pullup_enable <= req.wdata;
			end
		end
	end

	// Port C registers, only two pins exist
	always_ff @(posedge clk) begin
		if (clr) begin
			port_c_data          <= `GPP_RST_DATA & `GPP_MASK_C;
			port_c_direction     <= `GPP_RST_DIR & `GPP_MASK_C;
			port_c_pullup_enable <= `GPP_RST_PULL;
		end else begin
			// Upper six bits are dropped on every write
			if (hit(req, `GPP_ADDR_C_DATA)) begin
				port_c_data <= req.wdata & `GPP_MASK_C;
			end
			if (hit(req, `GPP_ADDR_C_DIR)) begin
				port_c_direction <= req.wdata & `GPP_MASK_C;
			end
			if (hit(req, `GPP_ADDR_C_PULL)) begin
				port_c_pullup_enable <= req.wdata & `GPP_MASK_C;
			end
		end
	end

	// Pull strength and source current selects
	always_ff @(posedge clk) begin
		if (clr) begin
			low_voltage_pull_select  <= `GPP_RST_LV;
			drive_strength_select_lo <= `GPP_RST_DRIVE;
			drive_strength_select_hi <= `GPP_RST_DRIVE;
		end else begin
			// One strength bit applies to every enabled pull-up
			if (hit(req, `GPP_ADDR_LV_PULL)) begin
				low_voltage_pull_select <= req.wdata & `GPP_MASK_LV;
			end
			if (hit(req, `GPP_ADDR_DRIVE_LO)) begin
				drive_strength_select_lo <= req.wdata;
			end
			// Only two bits exist for port C
			if (hit(req, `GPP_ADDR_DRIVE_HI)) begin
				drive_strength_select_hi <= req.wdata & `GPP_MASK_C;
			end
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = `GPP_RST_RDATA;
		case (req.addr)
			// Data reads mix live pins and latches
			`GPP_ADDR_A_DATA: begin
				next_rdata = read_mix(dir_a_eff, port_a_data, pin_sync.a);
			end
			`GPP_ADDR_B_DATA: begin
				next_rdata = read_mix(port_b_direction, port_b_data,
					pin_sync.b);
			end
			`GPP_ADDR_C_DATA: begin
				next_rdata = read_mix(port_c_direction, port_c_data,
					{6'h00, pin_sync.c}) & `GPP_MASK_C;
			end
			// Control registers already hold zeros in missing bits
			`GPP_ADDR_A_DIR: begin
				next_rdata = port_a_direction;
			end
			`GPP_ADDR_A_PULL: begin
				next_rdata = port_a_pullup_enable;
			end
			`GPP_ADDR_A_WAKE: begin
				next_rdata = port_a_wakeup_enable;
			end
			`GPP_ADDR_B_DIR: begin
				next_rdata = port_b_direction;
			end
			`GPP_ADDR_B_PULL: begin
				next_rdata = port_b_pullup_enable;
			end
			`GPP_ADDR_C_DIR: begin
				next_rdata = port_c_direction;
			end
			`GPP_ADDR_C_PULL: begin
				next_rdata = port_c_pullup_enable;
			end
			`GPP_ADDR_LV_PULL: begin
				next_rdata = low_voltage_pull_select;
			end
			`GPP_ADDR_DRIVE_LO: begin
				next_rdata = drive_strength_select_lo;
			end
			`GPP_ADDR_DRIVE_HI: begin
				next_rdata = drive_strength_select_hi;
			end
			default: begin
				next_rdata = `GPP_RST_RDATA;
			end
		endcase
	end

	// Read answer registered; pin value frozen at the take edge
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata    <= `GPP_RST_RDATA;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_take;
			// Data holds between reads
			if (rd_take) begin
				rdata <= next_rdata;
			end
		end
	end

	// Pin drivers follow the latch and direction one cycle later
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_out  <= '1;
			pin_oe_n <= '1;
		end else begin
			pin_out  <= {port_a_data, port_b_data, port_c_data[1:0]};
			// Enable low drives; direction one means input
			pin_oe_n <= {dir_a_eff, port_b_direction,
				port_c_direction[1:0]};
		end
	end

	// Pull-ups need the enable bit, an input pin and a permitting function
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_pullup_enable <= '0;
			pull_strength     <= 1'b0;
		end else begin
			pin_pullup_enable <= pull_allowed & {
				port_a_pullup_enable & dir_a_eff,
				port_b_pullup_enable & port_b_direction,
				port_c_pullup_enable[1:0] & port_c_direction[1:0]};
			pull_strength <= low_voltage_pull_select[0];
		end
	end

	// Source current levels; pad applies them only to CMOS outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			drive_level <= '0;
		end else begin
			drive_level <= {drive_strength_select_hi[1:0],
				drive_strength_select_lo};
		end
	end

endmodule

// ===== test/gpp_ports_chk.sv
// Checker watching the ports of the GPIO ports block
`timescale 1ns/1ps
module gpp_ports_chk (
	input wire logic               clk,
	input wire logic               rst,
	input wire logic               wdt_timeout,
	input wire logic               standby,
	input wire gpp_pkg::gpp_req_s  req,
	input wire logic               second_instruction_phase,
	input wire logic [7:0]         rdata,
	input wire logic               rd_valid,
	input wire gpp_pkg::gpp_pins_s pull_allowed,
	input wire gpp_pkg::gpp_pins_s pin_oe_n,
	input wire gpp_pkg::gpp_pins_s pin_pullup_enable,
	input wire logic               pull_strength,
	input wire gpp_pkg::gpp_drive_s drive_level,
	input wire logic               wake
);
	// One clock domain, so one clocking and one disable
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Read answered one edge after a strobed request
	a_read_answer:
		assert property (req.rd && second_instruction_phase |=> rd_valid)
		else $error("strobed read not answered");
	a_read_refused:
		assert property (!(req.rd && second_instruction_phase) |=> !rd_valid)
		else $error("answer without strobed read");
	a_rdata_holds:
		assert property (!rd_valid |-> $stable(rdata))
		else $error("read data moved without a read");
	// Pull-up follows the shared-function gate of the previous edge
	a_pull_gated:
		assert property ((pin_pullup_enable & ~$past(pull_allowed)) == '0)
		else $error("pull-up on for a disallowed function");
	a_pull_input:
		assert property ((pin_pullup_enable & ~pin_oe_n) == '0)
		else $error("pull-up on a driven pin");
	a_pin2_input:
		assert property (pin_oe_n.a[2] && !pin_pullup_enable.a[2])
		else $error("port A pin 2 driven or pulled");
	a_wake_standby:
		assert property (wake |-> $past(standby))
		else $error("wake outside standby");
	a_wake_pulse:
		assert property (wake |=> !wake)
		else $error("wake longer than one cycle");
	// Registered outputs show the cleared registers two edges later
	a_wdt_clears:
		assert property (wdt_timeout && !standby && !req.wr |->
			##2 (drive_level == '0 && !pull_strength))
		else $error("normal timeout left drive select set");
	a_sleep_keeps:
		assert property (wdt_timeout && standby && !req.wr |->
			##2 ($stable(drive_level) && $stable(pull_strength)))
		else $error("standby timeout changed drive select");
endmodule

bind gpp_ports gpp_ports_chk u_chk (.clk, .rst, .wdt_timeout, .standby,
	.req, .second_instruction_phase, .rdata, .rd_valid, .pull_allowed,
	.pin_oe_n, .pin_pullup_enable, .pull_strength, .drive_level, .wake);

// ===== test/gpp_board.sv
// Board model: a push-pull source on every pin, beaten by the port
`timescale 1ns/1ps
module gpp_board (
	input  wire gpp_pkg::gpp_pins_s pin_out,
	input  wire gpp_pkg::gpp_pins_s pin_oe_n,
	input  wire gpp_pkg::gpp_pins_s ext,
	output gpp_pkg::gpp_pins_s      level
);
	// Driven pins show the latch; released pins show the board source
	assign level = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule

// ===== test/tb.sv
// Self-checking bench for the GPIO ports block
`timescale 1ns/1ps
`include "gpp_map.svh"
module tb;
	logic                clk = 0, rst = 1, wdt = 0, stby = 0, ph = 0;
	gpp_pkg::gpp_req_s   req = '0;
	gpp_pkg::gpp_pins_s  ext = '1, allow = '0, lvl, po, oen, pu;
	gpp_pkg::gpp_drive_s drv;
	logic [7:0]          sel = '0, rdata;
	logic                rdv, pst, wk;
	logic [7:0]          m [0:12]; // Register model
	int                  bad_count = 0, checks_done = 0, cyc = 0, n;

	always #5 clk = ~clk;

	gpp_ports dut (.clk, .rst, .wdt_timeout(wdt), .standby(stby), .req,
		.second_instruction_phase(ph), .rdata, .rd_valid(rdv),
		.pin_in(lvl), .pull_allowed(allow), .port_a_gpio_sel(sel),
		.pin_out(po), .pin_oe_n(oen), .pin_pullup_enable(pu),
		.pull_strength(pst), .drive_level(drv), .wake(wk));
	gpp_board board (.pin_out(po), .pin_oe_n(oen), .ext, .level(lvl));

	// Implemented bits of each location
	function automatic logic [7:0] msk(int a);
		case (a)
			1, 2, 3: return `GPP_MASK_A_CTRL;
			7, 8, 9, 12: return `GPP_MASK_C;
			10: return `GPP_MASK_LV;
			default: return `GPP_MASK_FULL;
		endcase
	endfunction

	// Data and direction come up all ones, the rest zero
	task automatic mreset();
		for (int a = 0; a < 13; a++)
			m[a] = (a < 2 || a == 4 || a == 5 || a == 7 || a == 8)
				? msk(a) : 8'h00;
	endtask

	// Input pins read the board, output pins read the latch
	function automatic logic [7:0] rexp(int a);
		logic [7:0] d;
		logic [7:0] x;
		d = (a == 0) ? (m[1] | 8'h04) : (a == 4) ? m[5] : m[8];
		x = (a == 0) ? ext.a : (a == 4) ? ext.b : {6'h00, ext.c};
		if (a > 12) return 8'h00;
		if (a != 0 && a != 4 && a != 7) return m[a];
		return ((d & x) | (~d & m[a])) & msk(a);
	endfunction

	task automatic cmp(string what, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(int a, logic [7:0] d);
		@(posedge clk);
		req <= {2'b10, 8'(a), d};
		@(posedge clk);
		req <= '0;
		if (a < 13) m[a] = d & msk(a);
	endtask

	// Strobed or bare read; answer looked at mid-cycle
	task automatic rd(int a, logic s);
		@(posedge clk);
		req <= {2'b01, 8'(a), 8'h00};
		ph <= s;
		@(posedge clk);
		req <= '0;
		ph <= 0;
		@(negedge clk);
		cmp("valid", rdv, s);
		if (s) cmp("rdata", rdata, rexp(a));
	endtask

	task automatic all();
		logic [17:0] d;
		repeat (6) @(posedge clk);
		// Look mid-cycle, away from the edge that updates the outputs
		@(negedge clk);
		d = {m[1] | 8'h04, m[5], m[8][1:0]};
		cmp("oe_n", oen, d);
		cmp("out", po, {m[0], m[4], m[7][1:0]});
		cmp("pull", pu, {m[2], m[6], m[9][1:0]} & d & allow);
		cmp("lvsel", pst, m[10][0]);
		cmp("drive", drv, {m[12][1:0], m[11]});
		for (int a = 0; a < 14; a++) rd(a, 1);
	endtask

	task automatic pulse(logic s);
		@(posedge clk);
		stby <= s;
		wdt <= 1;
		@(posedge clk);
		wdt <= 0;
		stby <= 0;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Hang guard, well above the few thousand cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			conclude();
		end
	end

	initial begin
		mreset();
		n = $urandom(32);
		repeat (12) @(posedge clk);
		rst <= 0;
		all();
		rd(0, 0);
		$display("test reset values done");
		// Random writes anywhere, board and function gates moving
		for (int i = 0; i < 60; i++) begin
			@(posedge clk);
			ext <= 18'($urandom);
			allow <= 18'($urandom);
			wr($urandom_range(13), 8'($urandom));
			all();
		end
		$display("test random access done");
		wr(0, 8'h5A);
		wr(11, 8'hC3);
		wr(10, 8'h01);
		pulse(1);
		all();
		pulse(0);
		mreset();
		all();
		$display("test timeout done");
		// Reset in mid-run must bring back the power-on values
		wr(6, 8'hA5);
		wr(12, 8'h03);
		@(posedge clk);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		mreset();
		all();
		$display("test mid-run reset done");
		// Falling edge per port A pin, random gate and standby
		wr(1, 8'hFF);
		wr(3, 8'hFF);
		for (int b = 0; b < 8; b++) begin
			@(posedge clk);
			sel <= 8'($urandom);
			stby <= 1'($urandom);
			ext <= '1;
			repeat (4) @(posedge clk);
			ext.a[b] <= 0;
			n = 0;
			repeat (8) begin
				@(negedge clk);
				if (wk === 1'b1) n++;
			end
			cmp("wake", n, stby && b != 2 && sel[b]);
		end
		$display("test wake done");
		conclude();
	end
endmodule
